// *** verilog/rx_regs_consts.svh ***
/*
   Offsets, field positions, masks, reset values and timing figures of the
   receive pointer, threshold and interrupt register group.
   Assumes inclusion by bare name from the design files.
*/
`ifndef RX_REGS_CONSTS_SVH
`define RX_REGS_CONSTS_SVH

// register byte offsets (low byte of each 16-bit register)
`define OFS_RX_FRAME_DATA_POINTER 8'h86
`define OFS_RX_DURATION_THRESHOLD 8'h8c
`define OFS_RX_BYTE_COUNT_THRESHOLD 8'h8e
`define OFS_INTERRUPT_ENABLE 8'h90
`define OFS_INTERRUPT_STATUS 8'h92

// frame data pointer fields
`define POS_RX_POINTER_AUTO_INC 14
`define RX_FRAME_POINTER_RESET 11'h000

// reset values
`define RX_DURATION_THRESHOLD_RESET 16'h0000
`define RX_BYTE_COUNT_THRESHOLD_RESET 16'h0000
`define INTERRUPT_ENABLE_RESET 16'h0000
`define INTERRUPT_STATUS_RESET 16'h0300

// implemented bits of the enable register and write-one-to-clear bits of the status register
`define INTERRUPT_ENABLE_MASK 16'heb7f
`define INTERRUPT_STATUS_W1C_MASK 16'heb42

// status and enable bit positions
`define POS_LINK_CHANGE 15
`define POS_TRANSMIT_DONE 14
`define POS_FRAME_RECEIVED 13
`define POS_RECEIVE_OVERRUN 11
`define POS_TX_STOPPED 9
`define POS_RX_STOPPED 8
`define POS_TX_SPACE 6
`define POS_WAKE_FRAME 5
`define POS_WAKE_PACKET 4
`define POS_LINKUP 3
`define POS_ENERGY 2
`define POS_HOST_BUS_ERROR 1
`define POS_DELAYED_ENERGY 0

// duration threshold step and core clock period
`define DURATION_STEP_NS 1000
`define CLK_PERIOD_NS 20
`define DURATION_STEP_CYCLES (`DURATION_STEP_NS / `CLK_PERIOD_NS)

`endif

// *** verilog/rx_regs_pkg.sv ***
/*
   Types shared by the receive register group and its duration timer.
   Assumes nothing of its surroundings.
*/
package rx_regs_pkg;

   // width of one frame data access
   typedef enum logic [1:0] {
      access_byte = 2'h0,
      access_word = 2'h1,
      access_dword = 2'h2
   } access_size_type;

   // duration timer states, gray along idle -> run -> fired
   typedef enum logic [1:0] {
      timer_idle = 2'h0,
      timer_run = 2'h1,
      timer_fired = 2'h3
   } timer_state_type;

endpackage

// *** verilog/rx_duration_timer.sv ***
/*
   Microsecond duration timer for the receive queue: counts whole
   microseconds since the first frame entered the queue and flags once
   when the count exceeds the programmed threshold.
   Assumes a 50 MHz core clock and a queue-occupied level synchronous to it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rx_regs_consts.svh"

module rx_duration_timer #(
   parameter int STEP_CYCLES = `DURATION_STEP_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // control
   input wire logic enable,
   input wire logic queue_occupied,
   input wire logic [15:0] threshold,
   // result
   output logic expired
);
   import rx_regs_pkg::*;

   timer_state_type state_reg;
   logic [15:0] prescale_reg;
   logic [15:0] usec_reg;

   // state: run while frames sit in the queue, fire once per occupancy
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_reg <= timer_idle;
      end else begin
         case (state_reg)
            timer_idle: begin
               if (queue_occupied)
                  state_reg <= timer_run;
            end
            timer_run: begin
               if (!queue_occupied)
                  state_reg <= timer_idle;
               else if (enable && usec_reg > threshold)
                  state_reg <= timer_fired;
            end
            timer_fired: begin
               if (!queue_occupied)
                  state_reg <= timer_idle;
            end
            default: state_reg <= timer_idle;
         endcase
      end
   end

   // microsecond prescaler and saturating count; cleared when the queue empties
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         prescale_reg <= 16'h0000;
         usec_reg <= 16'h0000;
      end else if (state_reg == timer_idle) begin
         prescale_reg <= 16'h0000;
         usec_reg <= 16'h0000;
      end else if (prescale_reg == 16'(STEP_CYCLES - 1)) begin
         prescale_reg <= 16'h0000;
         if (usec_reg != 16'hffff)
            usec_reg <= usec_reg + 16'h0001;
      end else begin
         prescale_reg <= prescale_reg + 16'h0001;
      end
   end

   // one-cycle pulse on entry to the fired state
   assign expired = (state_reg == timer_run) && queue_occupied && enable
      && (usec_reg > threshold);

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   step_period_a: assert property (
      usec_reg == 16'h0002 && $past(usec_reg) == 16'h0001
      |-> $past(usec_reg, STEP_CYCLES) == 16'h0001
      && $past(usec_reg, STEP_CYCLES + 1) == 16'h0000)
      else $error("microsecond step is not the documented length");

   fire_once_a: assert property (
      expired |=> !expired && state_reg == timer_fired)
      else $error("duration expiry fired twice in one occupancy");
endmodule
`default_nettype wire

// *** verilog/rx_pointer_irq_threshold_regs.sv ***
/*
   Host-visible register group: receive frame data pointer with optional
   auto-increment, receive duration and byte-count thresholds, interrupt
   enable and the edge-captured interrupt status that the enables gate.
   Assumes the serial host port has already decoded each command into a
   one-cycle register read or write with byte enables, and each frame
   data read into a one-cycle pulse with its access width. Event inputs
   are one-cycle pulses, wake inputs are levels, all synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rx_regs_consts.svh"

// Overview of operation
// - with auto-increment set, each frame data read advances the pointer
// - pointer steps by one, two or four for byte, word, dword reads
// - with auto-increment clear, data reads leave the pointer alone
// - duration threshold counts one-microsecond steps, at most 0xcfff; the register stores all 16 bits unmasked
// - duration enable set: receive status rises when time exceeds threshold
// - byte-count enable set: receive status rises when bytes exceed threshold
// - link change interrupt passes only while enable bit 15 is set
// - transmit done interrupt passes only while enable bit 14 is set
// - frame received interrupt passes only while enable bit 13 is set
// - receive overrun passes with bit 11; bits 12, 10, 7 reserved
// - transmit stopped uses bit 9, receive stopped bit 8, independently
// - transmit space available interrupt passes only while bit 6 is set
// - wake frame bit 5, wake packet bit 4, linkup 3, energy 2
// - host bus error interrupt passes only while enable bit 1 is set
// - delayed energy passes with bit 0, held until host access ready
// - interrupt output active when any enabled status bit is set
// - edge status bits survive reads; writing one clears them
module rx_pointer_irq_threshold_regs #(
   parameter int POINTER_WIDTH = 11,
   parameter int STEP_CYCLES = `DURATION_STEP_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // register access from the host port
   input wire logic [7:0] reg_addr,
   input wire logic [1:0] reg_byte_en,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [15:0] reg_write_data,
   output logic [15:0] reg_read_data,
   output logic reg_read_valid,
   // frame data reads from the receive queue
   input wire logic frame_data_read,
   input wire rx_regs_pkg::access_size_type frame_data_size,
   output logic [POINTER_WIDTH-1:0] rx_frame_pointer,
   // receive queue command enables and queue state
   input wire logic duration_thresh_en,
   input wire logic byte_count_thresh_en,
   input wire logic queue_occupied,
   input wire logic [15:0] queue_byte_count,
   // edge event pulses
   input wire logic link_change_event,
   input wire logic transmit_done_event,
   input wire logic frame_received_event,
   input wire logic receive_overrun_event,
   input wire logic tx_stopped_event,
   input wire logic rx_stopped_event,
   input wire logic tx_space_event,
   input wire logic host_bus_error_event,
   // wake status levels from the power event logic
   input wire logic wake_frame_status,
   input wire logic wake_packet_status,
   input wire logic linkup_status,
   input wire logic energy_status,
   input wire logic host_access_ready,
   // interrupt pin
   output logic interrupt_n
);
   import rx_regs_pkg::*;

   logic rx_pointer_auto_inc_reg;
   logic [POINTER_WIDTH-1:0] rx_frame_pointer_reg;
   logic [15:0] rx_duration_value_reg;
   logic [15:0] rx_byte_count_value_reg;
   logic [15:0] interrupt_enable_reg;
   logic [15:0] status_edge_reg;
   logic [15:0] interrupt_status;
   logic [15:0] event_set;
   logic [15:0] w1c_clear;
   logic [15:0] pending;
   logic bytes_over_reg;
   logic bytes_over;
   logic byte_count_fire;
   logic duration_fire;
   logic [15:0] read_value;
   logic interrupt_n_reg;

   // merge byte-enabled write data over an old register value
   function automatic logic [15:0] merge_bytes(input logic [15:0] old_value,
         input logic [15:0] new_value, input logic [1:0] lanes);
      merge_bytes = {lanes[1] ? new_value[15:8] : old_value[15:8],
                     lanes[0] ? new_value[7:0] : old_value[7:0]};
   endfunction

   // pointer step for one frame data access
   function automatic logic [POINTER_WIDTH-1:0] access_step(input access_size_type size);
      case (size)
         access_byte: access_step = POINTER_WIDTH'(1);
         access_word: access_step = POINTER_WIDTH'(2);
         access_dword: access_step = POINTER_WIDTH'(4);
         default: access_step = POINTER_WIDTH'(1);
      endcase
   endfunction

   // true when the address hits the given register, whether or not the cycle is a write
   function automatic logic hits(input logic [7:0] addr, input logic [7:0] offset);
      hits = (addr == offset);
   endfunction

   // auto-increment control bit lives in the high byte of the pointer register
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rx_pointer_auto_inc_reg <= 1'b0;
      end else if (reg_write && reg_byte_en[1]
            && hits(reg_addr, `OFS_RX_FRAME_DATA_POINTER)) begin
         rx_pointer_auto_inc_reg <= reg_write_data[`POS_RX_POINTER_AUTO_INC];
      end
   end

   // pointer: host write wins over a data read in the same cycle, since
   // software reloading the pointer means the old position is abandoned
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rx_frame_pointer_reg <= `RX_FRAME_POINTER_RESET;
      end else if (reg_write && hits(reg_addr, `OFS_RX_FRAME_DATA_POINTER)
            && reg_byte_en != 2'h0) begin
         rx_frame_pointer_reg <= POINTER_WIDTH'(merge_bytes(16'(rx_frame_pointer_reg),
            reg_write_data, reg_byte_en) & 16'h07ff);
      end else if (frame_data_read && rx_pointer_auto_inc_reg) begin
         rx_frame_pointer_reg <= rx_frame_pointer_reg + access_step(frame_data_size);
      end
   end

   assign rx_frame_pointer = rx_frame_pointer_reg;

   // duration threshold, a plain read-write register
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rx_duration_value_reg <= `RX_DURATION_THRESHOLD_RESET;
      end else if (reg_write && hits(reg_addr, `OFS_RX_DURATION_THRESHOLD)) begin
         rx_duration_value_reg <= merge_bytes(rx_duration_value_reg, reg_write_data,
            reg_byte_en);
      end
   end

   // byte-count threshold, a plain read-write register
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rx_byte_count_value_reg <= `RX_BYTE_COUNT_THRESHOLD_RESET;
      end else if (reg_write && hits(reg_addr, `OFS_RX_BYTE_COUNT_THRESHOLD)) begin
         rx_byte_count_value_reg <= merge_bytes(rx_byte_count_value_reg, reg_write_data,
            reg_byte_en);
      end
   end

   // enables; reserved positions are masked so they never store
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         interrupt_enable_reg <= `INTERRUPT_ENABLE_RESET;
      end else if (reg_write && hits(reg_addr, `OFS_INTERRUPT_ENABLE)) begin
         interrupt_enable_reg <= merge_bytes(interrupt_enable_reg, reg_write_data,
            reg_byte_en) & `INTERRUPT_ENABLE_MASK;
      end
   end

   // duration timer for the receive threshold interrupt
   rx_duration_timer #(
      .STEP_CYCLES(STEP_CYCLES)
   ) duration_timer (
      .clk(clk),
      .reset(reset),
      .enable(duration_thresh_en),
      .queue_occupied(queue_occupied),
      .threshold(rx_duration_value_reg),
      .expired(duration_fire)
   );

   // byte count crossing: only the rising edge sets status, so a queue
   // that stays above threshold does not re-raise after the host clears
   assign bytes_over = byte_count_thresh_en && (queue_byte_count > rx_byte_count_value_reg);
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         bytes_over_reg <= 1'b0;
      end else begin
         bytes_over_reg <= bytes_over;
      end
   end
   assign byte_count_fire = bytes_over && !bytes_over_reg;

   // event set vector for the edge-captured status bits
   always_comb begin
      event_set = 16'h0000;
      event_set[`POS_LINK_CHANGE] = link_change_event;
      event_set[`POS_TRANSMIT_DONE] = transmit_done_event;
      event_set[`POS_FRAME_RECEIVED] = frame_received_event || duration_fire
         || byte_count_fire;
      event_set[`POS_RECEIVE_OVERRUN] = receive_overrun_event;
      event_set[`POS_TX_STOPPED] = tx_stopped_event;
      event_set[`POS_RX_STOPPED] = rx_stopped_event;
      event_set[`POS_TX_SPACE] = tx_space_event;
      event_set[`POS_HOST_BUS_ERROR] = host_bus_error_event;
   end

   assign w1c_clear = (reg_write && hits(reg_addr, `OFS_INTERRUPT_STATUS))
      ? merge_bytes(16'h0000, reg_write_data, reg_byte_en) : 16'h0000;

   // edge status: a set in the clearing cycle wins, reads never clear
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         status_edge_reg <= `INTERRUPT_STATUS_RESET;
      end else begin
         status_edge_reg <= ((status_edge_reg & ~w1c_clear) | event_set)
            & `INTERRUPT_STATUS_W1C_MASK;
      end
   end

   // full status: edge bits plus the live wake levels
   always_comb begin
      interrupt_status = status_edge_reg;
      interrupt_status[`POS_WAKE_FRAME] = wake_frame_status;
      interrupt_status[`POS_WAKE_PACKET] = wake_packet_status;
      interrupt_status[`POS_LINKUP] = linkup_status;
      interrupt_status[`POS_ENERGY] = energy_status;
   end

   // gate each source by its own enable bit
   always_comb begin
      pending = interrupt_status & interrupt_enable_reg;
      pending[`POS_DELAYED_ENERGY] = energy_status
         && interrupt_enable_reg[`POS_DELAYED_ENERGY] && host_access_ready;
   end

   // registered, active-low interrupt pin
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         interrupt_n_reg <= 1'b1;
      end else begin
         interrupt_n_reg <= ~(|pending);
      end
   end
   assign interrupt_n = interrupt_n_reg;

   // read mux; the pointer field is write-only and reads as zero
   always_comb begin
      case (reg_addr)
         `OFS_RX_FRAME_DATA_POINTER:
            read_value = 16'(rx_pointer_auto_inc_reg) << `POS_RX_POINTER_AUTO_INC;
         `OFS_RX_DURATION_THRESHOLD: read_value = rx_duration_value_reg;
         `OFS_RX_BYTE_COUNT_THRESHOLD: read_value = rx_byte_count_value_reg;
         `OFS_INTERRUPT_ENABLE: read_value = interrupt_enable_reg;
         `OFS_INTERRUPT_STATUS: read_value = interrupt_status;
         default: read_value = 16'h0000;
      endcase
   end

   // read data from flops, one cycle after the read strobe
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         reg_read_data <= 16'h0000;
         reg_read_valid <= 1'b0;
      end else begin
         reg_read_valid <= reg_read;
         if (reg_read)
            reg_read_data <= merge_bytes(16'h0000, read_value, reg_byte_en);
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   ptr_auto_step_a: assert property (
      frame_data_read && rx_pointer_auto_inc_reg && frame_data_size == access_dword
      && !reg_write |=> rx_frame_pointer == $past(rx_frame_pointer) + POINTER_WIDTH'(4))
      else $error("dword read did not advance pointer by four");

   ptr_manual_hold_a: assert property (
      !rx_pointer_auto_inc_reg && !reg_write |=> $stable(rx_frame_pointer))
      else $error("pointer moved without auto-increment");

   ptr_auto_word_a: assert property (
      frame_data_read && rx_pointer_auto_inc_reg && frame_data_size == access_word
      && !reg_write |=> rx_frame_pointer == $past(rx_frame_pointer) + POINTER_WIDTH'(2))
      else $error("word read did not advance pointer by two");

   bytes_raise_rx_a: assert property (
      byte_count_fire |=> interrupt_status[`POS_FRAME_RECEIVED])
      else $error("byte threshold crossing did not set receive status");

   status_sticky_a: assert property (
      status_edge_reg[`POS_LINK_CHANGE] && !w1c_clear[`POS_LINK_CHANGE]
      |=> status_edge_reg[`POS_LINK_CHANGE])
      else $error("link change status dropped without a clear");

   set_beats_clear_a: assert property (
      event_set[`POS_TRANSMIT_DONE] && w1c_clear[`POS_TRANSMIT_DONE]
      |=> status_edge_reg[`POS_TRANSMIT_DONE])
      else $error("event lost in its clearing cycle");

   irq_follows_a: assert property (
      |pending |=> !interrupt_n)
      else $error("enabled status did not assert interrupt");

   irq_masked_a: assert property (
      !interrupt_enable_reg[`POS_FRAME_RECEIVED] && (interrupt_status
      & interrupt_enable_reg) == 16'h0000 && !pending[`POS_DELAYED_ENERGY]
      |=> interrupt_n)
      else $error("interrupt asserted with no enabled source");

   reserved_zero_a: assert property (
      reg_read_valid && $past(reg_addr) == `OFS_INTERRUPT_ENABLE
      |-> (reg_read_data & ~`INTERRUPT_ENABLE_MASK) == 16'h0000
      && (status_edge_reg & ~`INTERRUPT_STATUS_W1C_MASK) == 16'h0000)
      else $error("reserved bit became set");

   delayed_energy_a: assert property (
      !host_access_ready && !(|(interrupt_status & interrupt_enable_reg))
      |=> interrupt_n)
      else $error("delayed energy interrupt before host ready");

   duration_raise_a: assert property (
      duration_fire |=> interrupt_status[`POS_FRAME_RECEIVED])
      else $error("duration expiry did not set receive status");

   ptr_auto_byte_a: assert property (
      frame_data_read && rx_pointer_auto_inc_reg && frame_data_size == access_byte
      && !reg_write |=> rx_frame_pointer == $past(rx_frame_pointer) + POINTER_WIDTH'(1))
      else $error("byte read did not advance pointer by one");

   ptr_write_load_a: assert property (
      reg_write && reg_addr == `OFS_RX_FRAME_DATA_POINTER && reg_byte_en == 2'h3
      |=> rx_frame_pointer == $past(reg_write_data[POINTER_WIDTH-1:0]))
      else $error("host pointer write did not load the pointer");
endmodule
`default_nettype wire

// *** tb/host_model.sv ***
/*
   Host processor model: issues one-cycle register reads and writes.
   Assumes a free-running clk; strobes change at the falling edge only.
*/
`timescale 1ns/1ps
`default_nettype none
module host_model (
   // clock
   input wire logic clk,
   // register strobes towards the device
   output logic [7:0] reg_addr,
   output logic [1:0] reg_byte_en,
   output logic reg_write,
   output logic reg_read,
   output logic [15:0] reg_write_data
);
   initial begin
      reg_addr = 8'h00;
      reg_byte_en = 2'h0;
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_write_data = 16'h0000;
   end

   // one access held over exactly one rising edge
   // idle data is inverted so nothing can lean on a stale value
   task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d,
                         input logic [1:0] be);
      @(negedge clk);
      reg_addr = a;
      reg_byte_en = be;
      reg_write_data = d;
      reg_write = wr;
      reg_read = ~wr;
      @(negedge clk);
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_write_data = ~d;
      reg_addr = ~a;
   endtask
endmodule
`default_nettype wire

// *** tb/tb_rx_pointer_irq_threshold_regs.sv ***
/*
   Self-checking bench for the receive pointer, threshold and interrupt registers.
   Assumes the host model drives the register port; events are driven here.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_rx_pointer_irq_threshold_regs;
   import rx_regs_pkg::*;
   logic clk, reset, reg_write, reg_read, reg_read_valid, frame_data_read, interrupt_n;
   logic duration_thresh_en, byte_count_thresh_en, queue_occupied, host_access_ready;
   logic [7:0] reg_addr, ev;
   logic [1:0] reg_byte_en;
   logic [3:0] wk;
   logic [15:0] reg_write_data, reg_read_data, queue_byte_count, d, p;
   logic [10:0] rx_frame_pointer;
   access_size_type frame_data_size;
   logic [15:0] exp_q[$];
   int err_total, num_checks;
   integer seed = 32'hf300f29b;
   int evp[8] = '{15, 14, 13, 11, 9, 8, 6, 1};
   int wkp[4] = '{5, 4, 3, 2};

   host_model i_host (.clk(clk), .reg_addr(reg_addr), .reg_byte_en(reg_byte_en),
      .reg_write(reg_write), .reg_read(reg_read), .reg_write_data(reg_write_data));

   // short microsecond step keeps the duration test brief
   rx_pointer_irq_threshold_regs #(.POINTER_WIDTH(11), .STEP_CYCLES(2)) i_dut (
      .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_byte_en(reg_byte_en),
      .reg_write(reg_write), .reg_read(reg_read), .reg_write_data(reg_write_data),
      .reg_read_data(reg_read_data), .reg_read_valid(reg_read_valid),
      .frame_data_read(frame_data_read), .frame_data_size(frame_data_size),
      .rx_frame_pointer(rx_frame_pointer), .duration_thresh_en(duration_thresh_en),
      .byte_count_thresh_en(byte_count_thresh_en), .queue_occupied(queue_occupied),
      .queue_byte_count(queue_byte_count), .link_change_event(ev[0]),
      .transmit_done_event(ev[1]), .frame_received_event(ev[2]),
      .receive_overrun_event(ev[3]), .tx_stopped_event(ev[4]), .rx_stopped_event(ev[5]),
      .tx_space_event(ev[6]), .host_bus_error_event(ev[7]), .wake_frame_status(wk[0]),
      .wake_packet_status(wk[1]), .linkup_status(wk[2]), .energy_status(wk[3]),
      .host_access_ready(host_access_ready), .interrupt_n(interrupt_n));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] v, input logic [1:0] be = 2'h3);
      i_host.access(1'b1, a, v, be);
   endtask

   // expected value noted before the strobe goes out
   task automatic rd(input logic [7:0] a, input logic [15:0] v);
      exp_q.push_back(v);
      i_host.access(1'b0, a, 16'h0000, 2'h3);
   endtask

   task automatic fdr(input access_size_type s);
      @(negedge clk);
      frame_data_read = 1'b1;
      frame_data_size = s;
      @(negedge clk);
      frame_data_read = 1'b0;
   endtask

   task automatic conclude;
      if (exp_q.size() != 0) err_total++;
      $display("checks=%0d errors=%0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // read results are matched against the oldest note
   always @(negedge clk) begin
      if (reg_read_valid === 1'b1) begin
         chk(reg_read_data, (exp_q.size() != 0) ? exp_q.pop_front() : 16'hxxxx);
      end
   end

   // hang guard, far above the expected run of a few hundred cycles
   initial begin
      #40000;
      err_total++;
      conclude();
   end

   initial begin
      reset = 1'b1;
      {queue_occupied, host_access_ready, ev, wk} = 14'h0000;
      {frame_data_read, duration_thresh_en, byte_count_thresh_en} = 3'h0;
      frame_data_size = access_byte;
      queue_byte_count = 16'h0000;
      cyc(3);
      reset = 1'b0;
      chk({15'h0, interrupt_n}, 16'h0001);
      chk({5'h0, rx_frame_pointer}, 16'h0000);
      rd(8'h8c, 16'h0000);
      rd(8'h8e, 16'h0000);
      rd(8'h90, 16'h0000);
      rd(8'h92, 16'h0300);
      rd(8'h88, 16'h0000);
      wr(8'h90, 16'hffff);
      rd(8'h90, 16'heb7f);
      repeat (4) begin
         d = 16'($random(seed));
         wr(8'h90, d);
         rd(8'h90, d & 16'heb7f);
         wr(8'h8c, d & 16'hcfff);
         rd(8'h8c, d & 16'hcfff);
         wr(8'h8e, d);
         rd(8'h8e, d);
      end
      wr(8'h8e, 16'hab12, 2'h1);
      rd(8'h8e, {d[15:8], 8'h12});
      // pointer zeroed with auto-increment on, then every access width
      wr(8'h86, 16'h4000);
      p = 16'h0000;
      for (int i = 0; i < 3; i++) begin
         fdr(access_size_type'(i));
         p = p + (16'h1 << i);
         chk({5'h0, rx_frame_pointer}, p);
      end
      rd(8'h86, 16'h4000);
      wr(8'h86, 16'h47fe);
      fdr(access_word);
      chk({5'h0, rx_frame_pointer}, 16'h0000);
      wr(8'h86, 16'h07ff);
      fdr(access_dword);
      chk({5'h0, rx_frame_pointer}, 16'h07ff);
      // each event is gated by its own enable bit only
      wr(8'h90, 16'h0000);
      wr(8'h92, 16'hffff);
      rd(8'h92, 16'h0000);
      for (int k = 0; k < 8; k++) begin
         @(negedge clk) ev[k] = 1'b1;
         @(negedge clk) ev[k] = 1'b0;
         wr(8'h90, ~(16'h1 << evp[k]));
         cyc(2);
         chk({15'h0, interrupt_n}, 16'h0001);
         rd(8'h92, 16'h1 << evp[k]);
         wr(8'h90, 16'h1 << evp[k]);
         cyc(2);
         chk({15'h0, interrupt_n}, 16'h0000);
         wr(8'h92, 16'h1 << evp[k]);
         cyc(2);
         chk({15'h0, interrupt_n}, 16'h0001);
      end
      // event and its clear in one cycle: the event must survive
      fork
         wr(8'h92, 16'h4000);
         begin
            @(negedge clk) ev[1] = 1'b1;
            @(negedge clk) ev[1] = 1'b0;
         end
      join
      rd(8'h92, 16'h4000);
      wr(8'h92, 16'h4000);
      for (int j = 0; j < 4; j++) begin
         wr(8'h90, 16'h0000);
         wk[j] = 1'b1;
         cyc(2);
         chk({15'h0, interrupt_n}, 16'h0001);
         rd(8'h92, 16'h1 << wkp[j]);
         wr(8'h90, 16'h1 << wkp[j]);
         cyc(2);
         chk({15'h0, interrupt_n}, 16'h0000);
         wk[j] = 1'b0;
         cyc(2);
         chk({15'h0, interrupt_n}, 16'h0001);
      end
      // delayed energy waits for host readiness
      wr(8'h90, 16'h0001);
      wk[3] = 1'b1;
      cyc(3);
      chk({15'h0, interrupt_n}, 16'h0001);
      host_access_ready = 1'b1;
      cyc(3);
      chk({15'h0, interrupt_n}, 16'h0000);
      {wk[3], host_access_ready} = 2'h0;
      wr(8'h90, 16'h0000);
      // byte count must exceed, not reach, the threshold
      wr(8'h8e, 16'h0010);
      byte_count_thresh_en = 1'b1;
      queue_byte_count = 16'h0010;
      cyc(3);
      rd(8'h92, 16'h0000);
      queue_byte_count = 16'h0011;
      cyc(3);
      rd(8'h92, 16'h2000);
      wr(8'h92, 16'h2000);
      byte_count_thresh_en = 1'b0;
      wr(8'h8c, 16'h0003);
      duration_thresh_en = 1'b1;
      queue_occupied = 1'b1;
      cyc(2);
      rd(8'h92, 16'h0000);
      cyc(20);
      rd(8'h92, 16'h2000);
      queue_occupied = 1'b0;
      cyc(4);
      conclude();
   end
endmodule
`default_nettype wire
